// ### rtl/bor_reset_pkg.sv
// Notes on behaviour
// - hold reset until power-on monitor releases
// - active monitor: reset while supply below threshold
// - one config bit selects brown-out threshold
// - filtered dips reset and clear brown-out flag
// - reset from all nine listed sources
// - optional power-up timer lengthens POR/BOR reset
// - mode 11: always on, start waits ready
// - mode 11: active in sleep, no wake delay
// - mode 10: active awake, ignored asleep
// - mode 10: wake waits ready and level
// - mode 10: execution waits for ready flag
// - mode 01: software bit enables monitor
// - mode 01, bit 0: start immediately
// - mode 01 bypass: bit 0, non-POR/BOR start
// - protection when ready; ready flag readable
// - mode 01: sleep leaves monitor unchanged
// - mode 00: monitor off, software bit ignored
// - forced on: ready before execution
// - power-up timer 64 ms after POR/BOR release
// - start needs timer, pin, oscillator done
// - late pin release: run after 10 clocks
// - low-power brown-out ORed into brown-out
package bor_reset_pkg;
    // -------------------------------------------------------------
    // constants
    // -------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_SW = 2'h1;
    localparam logic [1:0] MODE_NOSLEEP = 2'h2;
    localparam logic [1:0] MODE_ON = 2'h3;
    localparam int CLK_MHZ = 125;
    localparam int POWERUP_TIMER_MS = 64;
    localparam int POWERUP_TIMER_CYCLES = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
    localparam int FILTER_NS = 40;
    localparam int FILTER_CYCLES = (FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int EXTERNAL_RESET_PIN_RUN_CYCLES = 10;
    // register offsets and fields
    localparam logic [1:0] ADDR_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam int CTL_SWEN_BIT = 7;
    localparam int CTL_READY_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef struct packed {
        logic [1:0] brownout_mode_field;
        logic brownout_level_select;
        logic powerup_timer_enable;
        logic external_reset_pin_enable;
        logic low_power_brownout_enable;
        logic stack_reset_enable;
    } cfg_t;

    typedef struct packed {
        logic watchdog;
        logic reset_instr;
        logic stack_over;
        logic stack_under;
        logic prog_exit;
    } digital_src_t;
endpackage

// ### rtl/bor_reset_ctrl.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module bor_reset_ctrl #(
    parameter int POWERUP_TIMER_COUNT = bor_reset_pkg::POWERUP_TIMER_CYCLES
) (
    input wire logic core_clk, // system clock, 125 MHz
    input wire logic sys_rst, // async reset, active high
    input wire bor_reset_pkg::cfg_t cfg, // configuration bits
    input wire logic por_ok, // power-on monitor: supply ok (async)
    input wire logic bor_below, // brown-out comparator below (async)
    input wire logic bor_ready, // brown-out monitor ready (async)
    input wire logic low_power_brownout_below, // low-power brown-out below (async)
    input wire logic ext_reset_pin_n, // external reset pin, low resets (async)
    input wire logic osc_ready, // oscillator start-up done (async)
    input wire bor_reset_pkg::digital_src_t src, // same-clock reset requests
    input wire logic sleeping, // core is asleep
    input wire logic [1:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    output logic bor_enable, // monitor power enable
    output logic bor_level, // threshold select to monitor
    output logic device_reset, // device reset, active high
    output logic wake_ok // wake from sleep allowed
);
    // -------------------------------------------------------------
    // synchronisers
    // -------------------------------------------------------------
    logic [5:0] sync1;
    logic [5:0] sync2;
    // async indications pass two flops before use
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {por_ok, bor_below, bor_ready, low_power_brownout_below, ext_reset_pin_n, osc_ready};
            sync2 <= sync1;
        end
    end
    logic s_por;
    logic s_below;
    logic s_ready;
    logic s_low_power_brownout;
    logic s_pin;
    logic s_osc;
    assign {s_por, s_below, s_ready, s_low_power_brownout, s_pin, s_osc} = sync2;

    // -------------------------------------------------------------
    // monitor enable per mode
    // -------------------------------------------------------------
    logic sw_brownout_enable;
    logic next_mon_en;
    always_comb begin
        case (cfg.brownout_mode_field)
            bor_reset_pkg::MODE_ON: next_mon_en = 1'b1;
            bor_reset_pkg::MODE_NOSLEEP: next_mon_en = !sleeping;
            bor_reset_pkg::MODE_SW: next_mon_en = sw_brownout_enable;
            default: next_mon_en = 1'b0;
        endcase
    end
    // threshold choice follows one config bit
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bor_enable <= 1'b0;
            bor_level <= 1'b0;
        end else begin
            bor_enable <= next_mon_en;
            bor_level <= cfg.brownout_level_select;
        end
    end

    // -------------------------------------------------------------
    // brown-out filter
    // -------------------------------------------------------------
    localparam int FW = $clog2(bor_reset_pkg::FILTER_CYCLES + 1);
    logic [FW-1:0] filt_cnt;
    logic bor_trip;
    // protection counts only once the monitor reports ready; short dips are ignored
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            filt_cnt <= '0;
            bor_trip <= 1'b0;
        end else if (bor_enable && s_ready && s_below) begin
            if (filt_cnt == FW'(bor_reset_pkg::FILTER_CYCLES)) begin
                bor_trip <= 1'b1;
            end else begin
                filt_cnt <= filt_cnt + 1'b1;
            end
        end else begin
            filt_cnt <= '0;
            bor_trip <= 1'b0;
        end
    end
    logic lp_trip;
    assign lp_trip = cfg.low_power_brownout_enable && s_low_power_brownout;
    logic bor_any;
    assign bor_any = bor_trip || lp_trip;

    // -------------------------------------------------------------
    // software registers
    // -------------------------------------------------------------
    logic bor_flag_n; // brown-out status bit, 0 after brown-out
    logic por_flag_n;
    // software enable bit; in modes other than 01 it is stored but unused
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sw_brownout_enable <= 1'b1;
        end else if (reg_wr && reg_addr == bor_reset_pkg::ADDR_CONTROL) begin
            sw_brownout_enable <= reg_wdata[bor_reset_pkg::CTL_SWEN_BIT];
        end
    end
    // status flags: hardware clear wins over software set
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bor_flag_n <= 1'b0;
            por_flag_n <= 1'b0;
        end else begin
            if (bor_any) begin
                bor_flag_n <= 1'b0;
            end else if (reg_wr && reg_addr == bor_reset_pkg::ADDR_STATUS) begin
                bor_flag_n <= reg_wdata[0];
            end
            if (!s_por) begin
                por_flag_n <= 1'b0;
            end else if (reg_wr && reg_addr == bor_reset_pkg::ADDR_STATUS) begin
                por_flag_n <= reg_wdata[1];
            end
        end
    end
    // read data valid only the cycle after the strobe
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= bor_reset_pkg::STATUS_RESET;
        end else if (reg_rd) begin
            case (reg_addr)
                bor_reset_pkg::ADDR_CONTROL: reg_rdata <= {sw_brownout_enable, 6'h00,
                    s_ready && bor_enable};
                bor_reset_pkg::ADDR_STATUS: reg_rdata <= {6'h00, por_flag_n, bor_flag_n};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // -------------------------------------------------------------
    // reset sequencing
    // -------------------------------------------------------------
    typedef enum logic [2:0] {ST_POR, ST_POWERUP_TIMER, ST_WAIT, ST_PIN, ST_RUN} state_t;
    state_t state;
    logic [31:0] powerup_timer_cnt;
    logic [3:0] pin_cnt;
    logic pwr_event; // set by power-on or brown-out, cleared when execution starts
    logic pin_active;
    logic dig_reset;
    logic mon_gate;
    assign pin_active = cfg.external_reset_pin_enable && !s_pin;
    assign dig_reset = src.watchdog || src.reset_instr || src.prog_exit
        || (cfg.stack_reset_enable && (src.stack_over || src.stack_under));
    // start waits for monitor ready and level when it is forced on or mode 10
    always_comb begin
        case (cfg.brownout_mode_field)
            bor_reset_pkg::MODE_ON, bor_reset_pkg::MODE_NOSLEEP: mon_gate = s_ready && !s_below;
            bor_reset_pkg::MODE_SW: mon_gate = !sw_brownout_enable || (s_ready && !s_below);
            default: mon_gate = 1'b1;
        endcase
    end
    // main sequencer; power events restart the power-up timer
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_POR;
            powerup_timer_cnt <= 32'h0;
            pin_cnt <= 4'h0;
            pwr_event <= 1'b1;
        end else if (!s_por || bor_any) begin
            state <= ST_POR;
            pwr_event <= 1'b1;
            powerup_timer_cnt <= 32'h0;
        end else begin
            case (state)
                ST_POR: begin
                    state <= cfg.powerup_timer_enable ? ST_POWERUP_TIMER : ST_WAIT;
                    powerup_timer_cnt <= 32'h0;
                end
                ST_POWERUP_TIMER: begin
                    if (powerup_timer_cnt == 32'(POWERUP_TIMER_COUNT - 1)) begin
                        state <= ST_WAIT;
                    end else begin
                        powerup_timer_cnt <= powerup_timer_cnt + 32'h1;
                    end
                end
                ST_WAIT: begin
                    pin_cnt <= 4'h0;
                    if (!pin_active && s_osc && mon_gate && !dig_reset) begin
                        state <= ST_PIN;
                    end
                end
                ST_PIN: begin
                    if (pin_active || dig_reset) begin
                        state <= ST_WAIT;
                    end else if (pin_cnt == 4'(bor_reset_pkg::EXTERNAL_RESET_PIN_RUN_CYCLES - 1)) begin
                        state <= ST_RUN;
                        pwr_event <= 1'b0;
                    end else begin
                        pin_cnt <= pin_cnt + 4'h1;
                    end
                end
                ST_RUN: begin
                    if (pin_active || dig_reset) begin
                        state <= ST_WAIT;
                    end
                end
                default: state <= ST_POR;
            endcase
        end
    end
    // reset out and wake gating, both registered
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            device_reset <= 1'b1;
            wake_ok <= 1'b0;
        end else begin
            device_reset <= (state != ST_RUN);
            case (cfg.brownout_mode_field)
                bor_reset_pkg::MODE_ON: wake_ok <= 1'b1;
                bor_reset_pkg::MODE_NOSLEEP: wake_ok <= s_ready && !s_below;
                bor_reset_pkg::MODE_SW: wake_ok <= (!sw_brownout_enable && !pwr_event)
                    || (s_ready && !s_below);
                default: wake_ok <= 1'b1;
            endcase
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    a_por_holds_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
        !s_por |-> ##2 device_reset)
        else $error("reset not held while power-on low");

    a_mode_off_monitor: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg.brownout_mode_field == bor_reset_pkg::MODE_OFF |=> !bor_enable)
        else $error("monitor enabled in mode 00");
    a_sleep_disables: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.brownout_mode_field == bor_reset_pkg::MODE_NOSLEEP && sleeping) |=> !bor_enable)
        else $error("monitor on in sleep for mode 10");
    a_always_on: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg.brownout_mode_field == bor_reset_pkg::MODE_ON |=> bor_enable)
        else $error("monitor off in mode 11");
    a_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        bor_any |=> !bor_flag_n)
        else $error("brown-out flag not cleared");
    a_low_power_brownout_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
        lp_trip |=> ##1 device_reset)
        else $error("low-power brown-out did not reset");
    a_run_needs_ready: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_WAIT && cfg.brownout_mode_field == bor_reset_pkg::MODE_ON && !s_ready)
        |=> state != ST_PIN)
        else $error("start without monitor ready");
    a_pin_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(state == ST_RUN)
        |-> pin_cnt == 4'(bor_reset_pkg::EXTERNAL_RESET_PIN_RUN_CYCLES - 1))
        else $error("execution began before pin delay");

    a_level_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> bor_level == $past(cfg.brownout_level_select))
        else $error("threshold select not passed");
    a_digital_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_RUN && src.watchdog) |=> ##1 device_reset)
        else $error("watchdog did not reset");

    // -------------------------------------------------------------
    // assertions on filter, timing and mode gating
    // -------------------------------------------------------------
    // six filtered samples below the level must trip
    a_filter_trips: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bor_enable && s_ready && s_below) [*6]
        |=> bor_trip)
        else $error("long dip did not trip the filter");

    // a trip reaches the reset output two edges later
    a_trip_resets: assert property (@(posedge core_clk) disable iff (sys_rst)
        bor_trip
        |=> ##1 device_reset)
        else $error("brown-out trip did not reset");

    // the timer leaves only after its full count
    a_timer_length: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($past(state) == ST_POWERUP_TIMER && state == ST_WAIT)
        |-> powerup_timer_cnt == 32'(POWERUP_TIMER_COUNT - 1))
        else $error("power-up timer ended early");

    // with the timer off the sequencer skips it
    a_timer_skipped: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_POR && !cfg.powerup_timer_enable && s_por && !bor_any)
        |=> state == ST_WAIT)
        else $error("timer used while disabled");

    // pin held or oscillator pending keeps the wait
    a_start_blocked: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_WAIT && (pin_active || !s_osc))
        |=> state != ST_PIN)
        else $error("start while pin or oscillator pending");

    // mode 10 start waits for the ready flag
    a_nosleep_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_WAIT && cfg.brownout_mode_field == bor_reset_pkg::MODE_NOSLEEP && !s_ready)
        |=> state != ST_PIN)
        else $error("mode 10 start without ready");

    // mode 01 with the bit clear starts at once
    a_sw_off_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_WAIT && cfg.brownout_mode_field == bor_reset_pkg::MODE_SW
        && !sw_brownout_enable && !pin_active && s_osc && !dig_reset && s_por && !bor_any)
        |=> state == ST_PIN)
        else $error("mode 01 start delayed");

    // mode 01: monitor power tracks the software bit
    a_sw_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg.brownout_mode_field == bor_reset_pkg::MODE_SW
        |=> bor_enable == $past(sw_brownout_enable))
        else $error("monitor ignores software bit");

    // mode 01: sleep changes leave the monitor alone
    a_sw_sleep: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.brownout_mode_field == bor_reset_pkg::MODE_SW && $changed(sleeping)
        && $stable(sw_brownout_enable))
        |=> $stable(bor_enable))
        else $error("sleep changed monitor in mode 01");

    // mode 10 wake waits for ready
    a_nosleep_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.brownout_mode_field == bor_reset_pkg::MODE_NOSLEEP && !s_ready)
        |=> !wake_ok)
        else $error("mode 10 wake without ready");

    // mode 01 after a power event: wake waits for ready
    a_sw_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.brownout_mode_field == bor_reset_pkg::MODE_SW && pwr_event && !s_ready)
        |=> !wake_ok)
        else $error("mode 01 wake bypassed after power event");

    // mode 11 never delays wake
    a_on_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg.brownout_mode_field == bor_reset_pkg::MODE_ON
        |=> wake_ok)
        else $error("mode 11 wake delayed");

    // mode 00 has no monitor to wait for
    a_off_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        cfg.brownout_mode_field == bor_reset_pkg::MODE_OFF
        |=> wake_ok)
        else $error("mode 00 wake delayed");

    // brown-out ignored through a mode 10 sleep
    a_sleep_no_trip: assert property (@(posedge core_clk) disable iff (sys_rst)
        (cfg.brownout_mode_field == bor_reset_pkg::MODE_NOSLEEP && sleeping && $past(sleeping))
        |=> !bor_trip)
        else $error("brown-out tripped in mode 10 sleep");

    // ready bit reads back the synchronised monitor state
    a_ready_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == bor_reset_pkg::ADDR_CONTROL)
        |=> reg_rdata[bor_reset_pkg::CTL_READY_BIT] == $past(s_ready && bor_enable))
        else $error("ready flag not readable");

    // pin pulled low while running resets two edges later
    a_pin_resets: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state == ST_RUN && pin_active)
        |=> ##1 device_reset)
        else $error("pin did not reset");

endmodule

// ### verif/bor_monitor_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// supply monitors beside the reset block
// ------------------------------------------------------------
module bor_monitor_model (
    input wire logic core_clk, // system clock
    input wire logic bor_enable, // monitor power from the block
    input wire logic power_up, // supply has reached minimum level
    input wire logic supply_dip, // supply under the brown-out level
    input wire logic lp_dip, // supply under the low-power level
    input wire logic hold_ready, // keeps the monitor from settling
    output logic por_ok, // power-on monitor output
    output logic bor_below, // comparator output
    output logic bor_ready, // monitor settled
    output logic low_power_brownout_below, // low-power comparator output
    output logic osc_ready // oscillator running
);
    logic [2:0] warm = 3'h0;
    logic toggle = 1'b0;
    // monitor needs four cycles of power to settle; a powered-down
    // comparator gives no valid answer, so it wanders every cycle
    always_ff @(posedge core_clk) begin
        toggle <= ~toggle;
        if (!bor_enable) begin
            warm <= 3'h0;
        end else if (warm != 3'h4) begin
            warm <= warm + 3'h1;
        end
    end
    assign bor_ready = bor_enable && (warm == 3'h4) && !hold_ready;
    assign bor_below = bor_enable ? supply_dip : toggle;
    assign por_ok = power_up;
    assign osc_ready = power_up;
    assign low_power_brownout_below = lp_dip;
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic core_clk, sys_rst, power_up, supply_dip, lp_dip, hold_ready, ext_reset_pin_n;
    logic por_ok, bor_below, bor_ready, low_power_brownout_below, osc_ready, sleeping, reg_wr, reg_rd;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic bor_enable, bor_level, device_reset, wake_ok;
    bor_reset_pkg::cfg_t cfg;
    bor_reset_pkg::digital_src_t src;
    int num_errors = 0;
    int check_count = 0;
    bor_reset_ctrl #(.POWERUP_TIMER_COUNT(20)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cfg(cfg),
        .por_ok(por_ok), .bor_below(bor_below), .bor_ready(bor_ready),
        .low_power_brownout_below(low_power_brownout_below), .ext_reset_pin_n(ext_reset_pin_n), .osc_ready(osc_ready),
        .src(src), .sleeping(sleeping), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bor_enable(bor_enable),
        .bor_level(bor_level), .device_reset(device_reset), .wake_ok(wake_ok));
    bor_monitor_model mon_u (.core_clk(core_clk), .bor_enable(bor_enable),
        .power_up(power_up), .supply_dip(supply_dip), .lp_dip(lp_dip),
        .hold_ready(hold_ready), .por_ok(por_ok), .bor_below(bor_below),
        .bor_ready(bor_ready), .low_power_brownout_below(low_power_brownout_below), .osc_ready(osc_ready));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (num_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // look at outputs mid-cycle so edge updates have landed
    task automatic probe(input int n);
        tick(n);
        @(negedge core_clk);
    endtask
    task automatic wait_release(input int limit);
        for (int i = 0; i < limit && device_reset !== 1'b0; i++) probe(1);
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    function automatic bor_reset_pkg::cfg_t mk_cfg(input logic [1:0] m, input logic t);
        return '{m, 1'($urandom % 2), t, 1'b1, 1'b1, 1'b1};
    endfunction
    // fresh power-on with a new static configuration
    task automatic boot(input logic [1:0] m, input logic t);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        power_up <= 1'b0;
        cfg <= mk_cfg(m, t);
        tick(3);
        sys_rst <= 1'b0;
        tick(2);
        power_up <= 1'b1;
    endtask
    // a dip long enough to pass the filter, checking the reset outcome
    task automatic long_dip(input logic exp);
        @(posedge core_clk);
        supply_dip <= 1'b1;
        probe(12);
        chk("dip reset", device_reset, exp);
        @(posedge core_clk);
        supply_dip <= 1'b0;
        wait_release(80);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        d = $urandom(52061);
        sys_rst = 1'b1; power_up = 1'b0; supply_dip = 1'b0; lp_dip = 1'b0;
        hold_ready = 1'b0; ext_reset_pin_n = 1'b1; sleeping = 1'b0; src = '0;
        reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 2'h0; reg_wdata = 8'h00;
        cfg = mk_cfg(bor_reset_pkg::MODE_ON, 1'b1);
        tick(12);
        sys_rst <= 1'b0;
        probe(30);
        chk("no supply", device_reset, 1'b1);
        boot(bor_reset_pkg::MODE_ON, 1'b1);
        probe(26);
        chk("timer hold", device_reset, 1'b1);
        wait_release(60);
        chk("start on", device_reset, 1'b0);
        chk("always on", bor_enable, 1'b1);
        chk("level", bor_level, cfg.brownout_level_select);
        rd(bor_reset_pkg::ADDR_CONTROL, d);
        chk("control", d, 8'h81);
        wr(2'h3, 8'hFF);
        rd(2'h3, d);
        chk("unmapped", d, 8'h00);
        @(posedge core_clk);
        supply_dip <= 1'b1;
        tick(2);
        supply_dip <= 1'b0;
        probe(10);
        chk("short dip", device_reset, 1'b0);
        long_dip(1'b1);
        rd(bor_reset_pkg::ADDR_STATUS, d);
        chk("bor flag", d[0], 1'b0);
        sleeping <= 1'b1;
        probe(3);
        chk("sleep on", bor_enable, 1'b1);
        chk("wake on", wake_ok, 1'b1);
        long_dip(1'b1);
        @(posedge core_clk);
        sleeping <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            @(posedge core_clk);
            src <= bor_reset_pkg::digital_src_t'(5'h1 << i);
            @(posedge core_clk);
            src <= '0;
            probe(3);
            chk("source", device_reset, 1'b1);
            wait_release(40);
        end
        @(posedge core_clk);
        lp_dip <= 1'b1;
        probe(12);
        chk("low power dip", device_reset, 1'b1);
        @(posedge core_clk);
        lp_dip <= 1'b0;
        wait_release(80);
        @(posedge core_clk);
        ext_reset_pin_n <= 1'b0;
        probe(5);
        chk("pin low", device_reset, 1'b1);
        @(posedge core_clk);
        ext_reset_pin_n <= 1'b1;
        probe(9);
        chk("pin early", device_reset, 1'b1);
        probe(8);
        chk("pin run", device_reset, 1'b0);
        boot(bor_reset_pkg::MODE_NOSLEEP, 1'b0);
        hold_ready <= 1'b1;
        probe(40);
        chk("ready wait", device_reset, 1'b1);
        @(posedge core_clk);
        hold_ready <= 1'b0;
        wait_release(40);
        chk("ready start", device_reset, 1'b0);
        sleeping <= 1'b1;
        supply_dip <= 1'b1;
        probe(12);
        chk("sleep off", bor_enable, 1'b0);
        chk("sleep dip", device_reset, 1'b0);
        chk("wake held", wake_ok, 1'b0);
        @(posedge core_clk);
        sleeping <= 1'b0;
        supply_dip <= 1'b0;
        boot(bor_reset_pkg::MODE_SW, 1'b0);
        wait_release(60);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            wr(bor_reset_pkg::ADDR_CONTROL, d);
            probe(3);
            chk("sw enable", bor_enable, d[7]);
            @(posedge core_clk);
            sleeping <= ~sleeping;
            probe(3);
            chk("sw sleep", bor_enable, d[7]);
        end
        @(posedge core_clk);
        sleeping <= 1'b0;
        wr(bor_reset_pkg::ADDR_CONTROL, 8'h00);
        long_dip(1'b0);
        hold_ready <= 1'b1;
        src <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        @(posedge core_clk);
        src <= '0;
        wait_release(40);
        chk("sw bypass", device_reset, 1'b0);
        chk("sw wake", wake_ok, 1'b1);
        hold_ready <= 1'b0;
        boot(bor_reset_pkg::MODE_OFF, 1'b0);
        probe(26);
        chk("no timer", device_reset, 1'b0);
        rd(bor_reset_pkg::ADDR_STATUS, d);
        chk("power-on flag", d, 8'h00);
        wr(bor_reset_pkg::ADDR_STATUS, 8'h03);
        rd(bor_reset_pkg::ADDR_STATUS, d);
        chk("status write", d, 8'h03);
        wr(bor_reset_pkg::ADDR_CONTROL, 8'h80);
        probe(3);
        chk("off mode", bor_enable, 1'b0);
        long_dip(1'b0);
        give_verdict();
    end
    // watchdog: the whole sequence needs about six hundred cycles
    initial begin
        tick(20000);
        num_errors++;
        give_verdict();
    end
endmodule
